// [core/poll_wait_timer.sv]
/*
 Descriptor refetch wait timer. Counts the programmed number of clock
 cycles after a disabled descriptor, then pulses the refetch request.
 Assumes the caller gives a one-cycle start pulse on the same clock.
*/
`timescale 1ns/1ps
module poll_wait_timer
   import qsi_status_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Control
   input wire logic i_start,
   input wire logic [15:0] i_wait,
   // Status
   output logic o_busy,
   output logic o_refetch
);
   logic [15:0] remain_ff;

   // Zero wait refetches on the next cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         remain_ff <= 16'h0000;
         o_busy <= 1'b0;
         o_refetch <= 1'b0;
      end else begin
         o_refetch <= 1'b0;
         if (i_start && !o_busy) begin
            remain_ff <= i_wait;
            o_busy <= 1'b1;
         end else if (o_busy) begin
            if (remain_ff == 16'h0000) begin
               o_busy <= 1'b0;
               o_refetch <= 1'b1;
            end else begin
               remain_ff <= remain_ff - 16'h0001;
            end
         end
      end
   end
endmodule

// [core/qsi_status_pkg.sv]
/*
 Shared constants for the quad serial status and descriptor poll block:
 register indices, field positions, reset values and encodings.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package qsi_status_pkg;
   localparam logic [3:0] reg_status_two_idx = 4'h0;
   localparam logic [3:0] reg_poll_count_idx = 4'h1;
   localparam logic [3:0] reg_tx_dma_idx = 4'h2;
   localparam logic [3:0] reg_poll_ctrl_idx = 4'h3;

   localparam int cmd_dir_lsb = 16;
   localparam int ctrl_free_lsb = 7;
   localparam int line_act_lsb = 3;
   localparam int rx_under_bit = 1;
   localparam int tx_over_bit = 0;
   localparam int tx_state_lsb = 25;
   localparam int tx_space_lsb = 16;
   localparam int tx_len_lsb = 0;

   localparam logic [31:0] status_two_rst = 32'h0000_0000;
   localparam logic [15:0] poll_count_rst = 16'h0000;
   localparam logic [31:0] read_zero = 32'h0000_0000;

   typedef enum logic [1:0] {
      dir_idle = 2'b00,
      dir_tx = 2'b01,
      dir_rx = 2'b10
   } cmd_dir_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [3:0] addr;
      logic [31:0] wdata;
   } bus_req_s;

   typedef struct packed {
      logic [3:0] state;
      logic [4:0] space;
      logic [7:0] length;
   } tx_dma_s;
endpackage

// [core/quad_serial_status_poll.sv]
/*
 Status, descriptor poll and transmit DMA status registers of a quad
 serial flash controller. Assumes a simple register port on i_clk,
 data line pins from outside the clock domain, and engine events
 arriving as same-clock one-cycle pulses.
*/
// Decided for this implementation: the register offsets and strobed register access.
// Overview of operation
// - Two-bit command direction: idle 00, transmit 01, receive 10; 11 never shown.
// - Five-bit control FIFO free count, 0 to 31 encoding 0 to 32 bytes.
// - Bits 6 to 3 show activity on data lines 3 to 0.
// - Bit 1 sets when a receive FIFO read finds it empty.
// - Bit 0 sets when a write reaches a full transmit FIFO.
// - Disabled descriptor waits programmed 16-bit cycle count before refetch.
// - Unimplemented status bits 31-18, 15-12 and 2 read zero.
// - Transmit DMA state reported in a four-bit field, bits 28-25.
// - Five-bit FIFO space at 20-16, eight-bit buffer length at 7-0.
`timescale 1ns/1ps
module quad_serial_status_poll
   import qsi_status_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Register port
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Engine status, same clock
   input wire logic [1:0] i_command_direction,
   input wire logic [4:0] i_control_fifo_free,
   input wire logic i_rx_fifo_read,
   input wire logic i_rx_fifo_empty,
   input wire logic i_tx_fifo_write,
   input wire logic i_tx_fifo_full,
   input wire logic [3:0] i_tx_dma_state,
   input wire logic [4:0] i_tx_fifo_space,
   input wire logic [7:0] i_tx_current_length,
   // Descriptor processor
   input wire logic i_descriptor_disabled,
   output logic o_descriptor_refetch,
   output logic o_poll_waiting,
   // Data line pins, asynchronous
   input wire logic [3:0] i_data_line
);
   bus_req_s req;
   tx_dma_s tx_dma;
   logic [1:0] command_direction_ff;
   logic [4:0] control_fifo_free_ff;
   logic [3:0] line_meta_ff;
   logic [3:0] data_line_active_ff;
   logic rx_underflow_flag_ff;
   logic tx_overflow_flag_ff;
   logic [15:0] descriptor_poll_wait_ff;
   tx_dma_s tx_dma_ff;
   logic [31:0] status_word;
   logic [31:0] tx_dma_word;
   logic [31:0] nxt_rdata;
   logic refetch;
   logic waiting;

   assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};
   assign tx_dma = '{state: i_tx_dma_state, space: i_tx_fifo_space,
                     length: i_tx_current_length};

   // Reserved code never leaks out; shown as idle instead
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         command_direction_ff <= dir_idle;
      end else if (i_command_direction == 2'b11) begin
         command_direction_ff <= dir_idle;
      end else begin
         command_direction_ff <= i_command_direction;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         control_fifo_free_ff <= 5'h00;
      end else begin
         control_fifo_free_ff <= i_control_fifo_free;
      end
   end

   // Two-stage synchroniser per line; only stage two is read
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gen_line
         always_ff @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               line_meta_ff[g] <= 1'b0;
               data_line_active_ff[g] <= 1'b0;
            end else begin
               line_meta_ff[g] <= i_data_line[g];
               data_line_active_ff[g] <= line_meta_ff[g];
            end
         end
      end
   endgenerate

   // No clear path exists, so flags are sticky until reset
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_underflow_flag_ff <= 1'b0;
      end else if (i_rx_fifo_read && i_rx_fifo_empty) begin
         rx_underflow_flag_ff <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_overflow_flag_ff <= 1'b0;
      end else if (i_tx_fifo_write && i_tx_fifo_full) begin
         tx_overflow_flag_ff <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         descriptor_poll_wait_ff <= poll_count_rst;
      end else if (req.wr && req.addr == reg_poll_count_idx) begin
         descriptor_poll_wait_ff <= req.wdata[15:0];
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_dma_ff <= '0;
      end else begin
         tx_dma_ff <= tx_dma;
      end
   end

   poll_wait_timer u_poll_wait_timer (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_start(i_descriptor_disabled),
      .i_wait(descriptor_poll_wait_ff),
      .o_busy(waiting),
      .o_refetch(refetch)
   );

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_descriptor_refetch <= 1'b0;
         o_poll_waiting <= 1'b0;
      end else begin
         o_descriptor_refetch <= refetch;
         o_poll_waiting <= waiting;
      end
   end

   always_comb begin
      status_word = status_two_rst;
      status_word[cmd_dir_lsb +: 2] = command_direction_ff;
      status_word[ctrl_free_lsb +: 5] = control_fifo_free_ff;
      status_word[line_act_lsb +: 4] = data_line_active_ff;
      status_word[rx_under_bit] = rx_underflow_flag_ff;
      status_word[tx_over_bit] = tx_overflow_flag_ff;
   end

   always_comb begin
      tx_dma_word = read_zero;
      tx_dma_word[tx_state_lsb +: 4] = tx_dma_ff.state;
      tx_dma_word[tx_space_lsb +: 5] = tx_dma_ff.space;
      tx_dma_word[tx_len_lsb +: 8] = tx_dma_ff.length;
   end

   // Unmapped addresses read zero
   always_comb begin
      nxt_rdata = read_zero;
      case (req.addr)
         reg_status_two_idx: nxt_rdata = status_word;
         reg_poll_count_idx: nxt_rdata = {16'h0000, descriptor_poll_wait_ff};
         reg_tx_dma_idx: nxt_rdata = tx_dma_word;
         default: nxt_rdata = read_zero;
      endcase
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= read_zero;
      end else if (req.rd) begin
         o_rdata <= nxt_rdata;
      end else begin
         o_rdata <= read_zero;
      end
   end
endmodule

// [tb/flash_line_model.sv]
/*
 Far-side flash model: drives the four serial data lines.
 Assumes the bench supplies the pattern the flash sends.
*/
`timescale 1ns/1ps
module flash_line_model (
   // Clock and pattern
   input wire logic i_clk,
   input wire logic [3:0] i_pattern,
   // Data lines
   output logic [3:0] o_line
);
   // Lines move only after an edge, never with it
   always_ff @(posedge i_clk) begin
      o_line <= i_pattern;
   end
endmodule

// [tb/qssp_assertions.sv]
/*
 Port checker for the status and poll block.
 Assumes status inputs stay steady around register reads.
*/
`timescale 1ns/1ps
module qssp_assertions
   import qsi_status_pkg::*;
(
   // Watched ports
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_addr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0] i_command_direction,
   input wire logic [4:0] i_control_fifo_free,
   input wire logic i_rx_fifo_read,
   input wire logic i_rx_fifo_empty,
   input wire logic i_tx_fifo_write,
   input wire logic i_tx_fifo_full,
   input wire logic o_descriptor_refetch,
   input wire logic [3:0] i_data_line
);
   logic rs_ff, un_ff, ov_ff;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rs_ff <= 1'b0;
         un_ff <= 1'b0;
         ov_ff <= 1'b0;
      end else begin
         rs_ff <= i_rd && i_addr == reg_status_two_idx;
         un_ff <= un_ff || (i_rx_fifo_read && i_rx_fifo_empty);
         ov_ff <= ov_ff || (i_tx_fifo_write && i_tx_fifo_full);
      end
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   // Fields are captured one edge before the read strobe is taken
   property p_dir;
      rs_ff |-> o_rdata[17:16] ==
         (($past(i_command_direction, 2) == 2'b11) ? 2'b00 : $past(i_command_direction, 2));
   endproperty
   a_dir: assert property (p_dir) else $error("bad direction");
   property p_free; rs_ff |-> o_rdata[11:7] == $past(i_control_fifo_free, 2); endproperty
   a_free: assert property (p_free) else $error("bad free count");
   property p_line; rs_ff |-> o_rdata[6:3] == $past(i_data_line, 3); endproperty
   a_line: assert property (p_line) else $error("bad line bits");
   property p_zero; rs_ff |-> {o_rdata[31:18], o_rdata[15:12], o_rdata[2]} == 19'h0_0000; endproperty
   a_zero: assert property (p_zero) else $error("unused bits set");
   // Two-cycle slack: an event just before a read may land either side
   property p_under; rs_ff |-> o_rdata[1] <= un_ff && o_rdata[1] >= $past(un_ff, 2); endproperty
   a_under: assert property (p_under) else $error("bad underflow");
   property p_over; rs_ff |-> o_rdata[0] <= ov_ff && o_rdata[0] >= $past(ov_ff, 2); endproperty
   a_over: assert property (p_over) else $error("bad overflow");
   property p_pulse; o_descriptor_refetch |=> !o_descriptor_refetch; endproperty
   a_pulse: assert property (p_pulse) else $error("refetch too long");
   property p_idle; !$past(i_rd) |-> o_rdata == 32'h0000_0000; endproperty
   a_idle: assert property (p_idle) else $error("data without read");
   cover property (rs_ff && o_rdata[1]);
   cover property (rs_ff && o_rdata[0]);
   cover property (o_descriptor_refetch);
endmodule
bind quad_serial_status_poll qssp_assertions u_chk (.*);

// [tb/quad_serial_status_poll_tb.sv]
/*
 Self-checking bench for the status and poll block.
 Assumes package, design, flash model and checker compile first.
*/
`timescale 1ns/1ps
module quad_serial_status_poll_tb;
   import qsi_status_pkg::*;
   logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
   logic i_rx_fifo_empty = 1'b0, i_tx_fifo_full = 1'b0, o_descriptor_refetch, o_poll_waiting;
   logic [2:0] ev = 3'h0;
   wire logic i_rx_fifo_read = ev[0], i_tx_fifo_write = ev[1], i_descriptor_disabled = ev[2];
   logic [1:0] i_command_direction = 2'h0;
   logic [3:0] i_addr = 4'h0, i_tx_dma_state = 4'h0, pat = 4'h0, i_data_line;
   logic [4:0] i_control_fifo_free = 5'h00, i_tx_fifo_space = 5'h00;
   logic [7:0] i_tx_current_length = 8'h00;
   logic [31:0] i_wdata = 32'h0000_0000, o_rdata;
   int n_fail = 0, tests_run = 0;
   always #25 i_clk = ~i_clk;
   quad_serial_status_poll DUT (.*);
   flash_line_model u_flash (.i_clk(i_clk), .i_pattern(pat), .o_line(i_data_line));
   task automatic print_verdict;
      if (n_fail == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= w;
      i_rd <= !w;
      @(posedge i_clk);
      i_wr <= 1'b0;
      i_rd <= 1'b0;
      #1;
   endtask
   task automatic rc(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      tests_run++;
      if (o_rdata !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h want %h", $time, o_rdata, exp);
      end
   endtask
   task automatic pulse(input int b);
      ev[b] <= 1'b1;
      @(posedge i_clk);
      ev[b] <= 1'b0;
   endtask
   task automatic t_regs;
      rc(reg_poll_count_idx, 32'h0000_0000);
      bus(1'b1, reg_status_two_idx, 32'hFFFF_FFFF);
      bus(1'b1, reg_tx_dma_idx, 32'hFFFF_FFFF);
      rc(reg_status_two_idx, status_two_rst);
      rc(reg_poll_ctrl_idx, read_zero);
      rc(reg_tx_dma_idx, 32'h0000_0000);
   endtask
   task automatic t_status;
      logic [4:0] f;
      for (int i = 0; i < 4; i++) begin
         f = (i == 2) ? 5'h1F : 5'(i * i);
         i_command_direction <= 2'(i);
         i_control_fifo_free <= f;
         pat <= 4'(1 << i);
         repeat (4) @(posedge i_clk);
         rc(reg_status_two_idx, {14'h0000, (i == 3) ? 2'h0 : 2'(i), 4'h0, f, 4'(1 << i), 3'h0});
      end
      {i_command_direction, i_control_fifo_free, pat} <= 11'h000;
      repeat (4) @(posedge i_clk);
   endtask
   task automatic t_flags;
      pulse(0);
      pulse(1);
      rc(reg_status_two_idx, 32'h0000_0000);
      i_rx_fifo_empty <= 1'b1;
      pulse(0);
      i_rx_fifo_empty <= 1'b0;
      rc(reg_status_two_idx, 32'h0000_0002);
      i_tx_fifo_full <= 1'b1;
      pulse(1);
      i_tx_fifo_full <= 1'b0;
      rc(reg_status_two_idx, 32'h0000_0003);
      i_rst <= 1'b1;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      rc(reg_status_two_idx, 32'h0000_0000);
   endtask
   task automatic t_poll(input logic [15:0] n);
      int k = 0;
      bus(1'b1, reg_poll_count_idx, {16'hFFFF, n});
      rc(reg_poll_count_idx, {16'h0000, n});
      pulse(2);
      while (o_descriptor_refetch !== 1'b1 && k < 300) begin
         @(posedge i_clk);
         #1 k++;
         if (k == 1) begin
            tests_run++;
            if (o_poll_waiting !== 1'b1) begin
               n_fail++;
               $display("ERROR %0t poll wait not shown", $time);
            end
         end
      end
      tests_run++;
      if (o_poll_waiting !== 1'b0) begin
         n_fail++;
         $display("ERROR %0t poll wait still shown at refetch", $time);
      end
      rc(reg_poll_count_idx, {16'h0000, n});
      tests_run++;
      if (k >= 300) begin
         n_fail++;
         $display("ERROR %0t refetch timeout", $time);
      end else if (k !== int'(n) + 2) begin
         n_fail++;
         $display("ERROR %0t refetch after %0d cycles", $time, k);
      end
   endtask
   task automatic t_tx;
      i_tx_dma_state <= 4'hA;
      i_tx_fifo_space <= 5'h15;
      i_tx_current_length <= 8'hC3;
      rc(reg_tx_dma_idx, {3'h0, 4'hA, 4'h0, 5'h15, 8'h00, 8'hC3});
   endtask
   initial begin
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      t_regs();
      t_status();
      t_flags();
      t_poll(16'h0000);
      t_poll(16'h0007);
      t_tx();
      print_verdict();
   end
endmodule
